// ---- core/psp_pkg.sv ----
// Purpose: constants shared by the port D pin override block
// Assumes: one 100 MHz clock, AHB-Lite register access, whole-word transfers
package psp_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] PSP_OFS_CTRL  = 8'h00;
  localparam logic [7:0] PSP_OFS_DATA  = 8'h04;
  localparam logic [7:0] PSP_OFS_DIR   = 8'h08;
  localparam logic [7:0] PSP_OFS_STATE = 8'h0C;

  // ****************************************************************
  // control field positions and reset values
  // ****************************************************************
  localparam int PSP_CTRL_SEG_ON  = 0;
  localparam int PSP_CTRL_IRQ0_EN = 1;
  localparam int PSP_CTRL_PUD     = 2;
  localparam int PSP_CTRL_PM_LSB  = 4;
  localparam int PSP_PM_W         = 3;
  localparam logic [7:0] PSP_CTRL_RST = 8'h00;
  localparam logic [7:0] PSP_DATA_RST = 8'h00;
  localparam logic [7:0] PSP_DIR_RST  = 8'h00;

  // ****************************************************************
  // pin mask thresholds per pin pair
  // ****************************************************************
  localparam logic [2:0] PSP_PM_TOP = 3'h1;
  localparam logic [2:0] PSP_PM_B54 = 3'h2;
  localparam logic [2:0] PSP_PM_B32 = 3'h3;
  localparam logic [2:0] PSP_PM_B10 = 3'h4;

  localparam logic [1:0] PSP_HTRANS_NONSEQ = 2'h2;

endpackage

// ---- core/psp_ovr_if.sv ----
// Purpose: override enables and values passed from the decoder to the pin cells
// Assumes: eight pins, one bit per pin in each vector
// Notes: the top drives, the pin cell reads
`timescale 1ns/1ps
interface psp_ovr_if;
  logic [7:0] pullup_override_en;
  logic [7:0] pullup_override_val;
  logic [7:0] direction_override_en;
  logic [7:0] direction_override_val;
  logic [7:0] port_value_override_en;
  logic [7:0] port_value_override_val;
  logic [7:0] input_enable_override_en;
  logic [7:0] input_enable_override_val;
  logic [7:0] seg_claim;
  logic [7:0] seg_level;

  modport src  (output pullup_override_en, pullup_override_val, direction_override_en,
                direction_override_val, port_value_override_en, port_value_override_val,
                input_enable_override_en, input_enable_override_val, seg_claim, seg_level);
  modport sink (input pullup_override_en, pullup_override_val, direction_override_en,
                direction_override_val, port_value_override_en, port_value_override_val,
                input_enable_override_en, input_enable_override_val, seg_claim, seg_level);
endinterface

// ---- core/psp_pin_cell.sv ----
// Purpose: applies overrides to the eight port pins and registers the pad controls
// Assumes: pad input is synchronous to hclk
// Notes: every output is a flip-flop
`timescale 1ns/1ps
module psp_pin_cell (
  input  wire logic   hclk,
  input  wire logic   hresetn,
  psp_ovr_if.sink     ovr,
  input  wire logic [7:0] port_data,
  input  wire logic [7:0] port_dir,
  input  wire logic       pullup_disable,
  input  wire logic [7:0] pin_in,
  output logic [7:0]      pin_out,
  output logic [7:0]      pin_oe,
  output logic [7:0]      pin_pullup,
  output logic [7:0]      pin_input_en,
  output logic [7:0]      pin_di,
  output logic [7:0]      pin_seg
);

  // ****************************************************************
  // override muxes
  // ****************************************************************
  // plain port behaviour where no enable is set
  wire [7:0] dir_next = (ovr.direction_override_en & ovr.direction_override_val) |
                        (~ovr.direction_override_en & port_dir);
  wire [7:0] pu_plain = port_data & ~port_dir & {8{~pullup_disable}};
  wire [7:0] pu_next  = (ovr.pullup_override_en & ovr.pullup_override_val) |
                        (~ovr.pullup_override_en & pu_plain);
  wire [7:0] out_next = (ovr.port_value_override_en & ovr.port_value_override_val) |
                        (~ovr.port_value_override_en & port_data);
  wire [7:0] ie_next  = (ovr.input_enable_override_en & ovr.input_enable_override_val) |
                        ~ovr.input_enable_override_en;
  wire [7:0] seg_next = ovr.seg_claim & ovr.seg_level;

  // pad control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out      <= 8'h00;
      pin_oe       <= 8'h00;
      pin_pullup   <= 8'h00;
      pin_input_en <= 8'h00;
      pin_di       <= 8'h00;
      pin_seg      <= 8'h00;
    end else begin
      pin_out      <= out_next & dir_next;
      pin_oe       <= dir_next;
      pin_pullup   <= pu_next;
      pin_input_en <= ie_next;
      pin_di       <= pin_in & ie_next; // disabled inputs read zero
      pin_seg      <= seg_next;
    end
  end

endmodule

// ---- core/psp_port_d_mux.sv ----
// Purpose: port D pin sharing between port I/O, segment lines, irq zero and capture
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes: a read right after a write to the same register returns the old value
`timescale 1ns/1ps
module psp_port_d_mux (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic [7:0]  segment_lines,
  input  wire logic [7:0]  pin_in,
  output logic [7:0]       pin_out,
  output logic [7:0]       pin_oe,
  output logic [7:0]       pin_pullup,
  output logic [7:0]       pin_input_en,
  output logic [7:0]       pin_seg,
  output logic             ext_irq_zero_input,
  output logic             timer1_capture_input
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // segment line 15+k goes to pin bit 7-k
  function automatic logic [7:0] psp_reverse(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] ctrl_reg;
  logic [7:0] data_reg;
  logic [7:0] dir_reg;
  logic       wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] pin_di;

  wire                segment_driver_on = ctrl_reg[psp_pkg::PSP_CTRL_SEG_ON];
  wire                irq0_enable       = ctrl_reg[psp_pkg::PSP_CTRL_IRQ0_EN];
  wire                pullup_disable    = ctrl_reg[psp_pkg::PSP_CTRL_PUD];
  wire [2:0]          segment_pin_mask  = ctrl_reg[psp_pkg::PSP_CTRL_PM_LSB +: psp_pkg::PSP_PM_W];

  // ****************************************************************
  // claim decode
  // ****************************************************************
  wire claim_76 = segment_driver_on && (segment_pin_mask > psp_pkg::PSP_PM_TOP);
  wire claim_54 = segment_driver_on && (segment_pin_mask > psp_pkg::PSP_PM_B54);
  wire claim_32 = segment_driver_on && (segment_pin_mask > psp_pkg::PSP_PM_B32);
  wire claim_10 = segment_driver_on && (segment_pin_mask > psp_pkg::PSP_PM_B10);
  wire [7:0] claim = {claim_76, claim_76, claim_54, claim_54, claim_32, claim_32, claim_10, claim_10};

  psp_ovr_if ovr ();

  // pull-up and direction forced to zero on claimed pins
  assign ovr.pullup_override_en     = claim;
  assign ovr.pullup_override_val    = 8'h00;
  assign ovr.direction_override_en  = claim;
  assign ovr.direction_override_val = 8'h00;
  assign ovr.port_value_override_en  = 8'h00;
  assign ovr.port_value_override_val = 8'h00;
  // bit 1 keeps its input alive for the interrupt while the driver is on and irq0_enable is set; irq0_enable alone turns it off
  assign ovr.input_enable_override_en  = {claim[7:2], segment_driver_on | irq0_enable, claim[0]};
  assign ovr.input_enable_override_val = {6'h00, segment_driver_on & irq0_enable, 1'b0};
  assign ovr.seg_claim = claim;
  assign ovr.seg_level = psp_reverse(segment_lines);

  psp_pin_cell u_cell (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .ovr            (ovr.sink),
    .port_data      (data_reg),
    .port_dir       (dir_reg),
    .pullup_disable (pullup_disable),
    .pin_in         (pin_in),
    .pin_out        (pin_out),
    .pin_oe         (pin_oe),
    .pin_pullup     (pin_pullup),
    .pin_input_en   (pin_input_en),
    .pin_di         (pin_di),
    .pin_seg        (pin_seg)
  );

  // alternate input routing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_irq_zero_input   <= 1'b0;
      timer1_capture_input <= 1'b0;
    end else begin
      ext_irq_zero_input   <= pin_di[1];
      timer1_capture_input <= pin_di[0];
    end
  end

  // ****************************************************************
  // bus slave
  // ****************************************************************
  wire addr_phase = hsel && hready && (htrans == psp_pkg::PSP_HTRANS_NONSEQ || htrans == 2'h3);
  wire [31:0] rd_mux =
    (haddr == psp_pkg::PSP_OFS_CTRL)  ? {24'h000000, ctrl_reg} :
    (haddr == psp_pkg::PSP_OFS_DATA)  ? {24'h000000, data_reg} :
    (haddr == psp_pkg::PSP_OFS_DIR)   ? {24'h000000, dir_reg} :
    (haddr == psp_pkg::PSP_OFS_STATE) ? {16'h0000, claim, pin_di} : 32'h00000000;

  // address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata      <= 32'h00000000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      wr_addr_reg <= haddr;
      if (addr_phase && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // data phase writes; unmapped and state offsets ignore writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= psp_pkg::PSP_CTRL_RST;
      data_reg <= psp_pkg::PSP_DATA_RST;
      dir_reg  <= psp_pkg::PSP_DIR_RST;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == psp_pkg::PSP_OFS_CTRL) ctrl_reg <= hwdata[7:0] & 8'h77;
      if (wr_addr_reg == psp_pkg::PSP_OFS_DATA) data_reg <= hwdata[7:0];
      if (wr_addr_reg == psp_pkg::PSP_OFS_DIR)  dir_reg  <= hwdata[7:0];
    end
  end

endmodule

// ---- test/psp_pad_model.sv ----
// Purpose: pads of port D with the outside sources and the segment driver
// Assumes: external sources always drive, the pin cell wins where it drives
// Notes: purely combinational
`timescale 1ns/1ps
// ****************
// pad wire model
// ****************
module psp_pad_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] src_level,
  input  wire logic [7:0] seg_level,
  output logic [7:0]      pin_in,
  output logic [7:0]      segment_lines
);
  // wire level from the output enable alone, segment levels passed on
  assign pin_in        = (pin_oe & pin_out) | (~pin_oe & src_level);
  assign segment_lines = seg_level;
endmodule

// ---- test/psp_mux_monitor.sv ----
// Purpose: pad relations of the port D mux over time
// Assumes: one clock, reset active low
// Notes: sees only top ports
`timescale 1ns/1ps
// ****************
// checker
// ****************
module psp_mux_monitor (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] pin_input_en,
  input wire logic [7:0] pin_seg,
  input wire logic       ext_irq_zero_input,
  input wire logic       timer1_capture_input
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // claimed pins are released, claims nest by pair, irq zero and capture inputs follow the pads
  a_out_gated: assert property ((pin_out & ~pin_oe) == 8'h00) else $error("output high while not driving");
  a_seg_released: assert property ((pin_seg & (pin_oe | pin_pullup)) == 8'h00) else $error("segment pin driven");
  a_seg_no_input: assert property ((pin_seg & pin_input_en & 8'hFD) == 8'h00) else $error("segment pin input on");
  a_claim_undriven: assert property ((~pin_input_en & pin_oe & 8'hFD) == 8'h00) else $error("claimed pin driven");
  a_pairs_match: assert property (pin_input_en[7:6] != 2'h1 && pin_input_en[7:6] != 2'h2 && pin_input_en[5:4] != 2'h1
    && pin_input_en[5:4] != 2'h2 && pin_input_en[3:2] != 2'h1 && pin_input_en[3:2] != 2'h2) else $error("pair split");
  a_mask_nested: assert property ((pin_input_en[0] || !pin_input_en[2]) && (pin_input_en[2] || !pin_input_en[4])
    && (pin_input_en[4] || !pin_input_en[6])) else $error("claims not nested");
  a_irq_path: assert property ($stable(pin_in[1]) && $past(pin_in[1], 2) == pin_in[1] && $stable(pin_input_en[1])
    && $past(pin_input_en[1], 2) == pin_input_en[1] |-> ext_irq_zero_input == (pin_in[1] & pin_input_en[1]))
    else $error("irq zero input wrong");
  a_cap_path: assert property ($stable(pin_in[0]) && $past(pin_in[0], 2) == pin_in[0] && $stable(pin_input_en[0])
    && $past(pin_input_en[0], 2) == pin_input_en[0] |-> timer1_capture_input == (pin_in[0] & pin_input_en[0]))
    else $error("capture input wrong");
endmodule
bind psp_port_d_mux psp_mux_monitor u_psp_mux_monitor (.hclk, .hresetn, .pin_in, .pin_out, .pin_oe, .pin_pullup,
  .pin_input_en, .pin_seg, .ext_irq_zero_input, .timer1_capture_input);

// ---- test/port_d_segment_pin_override_bench.sv ----
// Purpose: random pin sharing configurations checked at pads and registers
// Assumes: zero wait bus, pads settle within four edges
// Notes: expectations queued by the driver, compared by monitors
`timescale 1ns/1ps
// ****************
// bench
// ****************
module port_d_segment_pin_override_bench;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, ext_irq_zero_input, timer1_capture_input;
  logic [7:0]  haddr, segment_lines, pin_in, pin_out, pin_oe, pin_pullup, pin_input_en, pin_seg, src, segv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  logic        rd_dp = 1'b0;
  logic [31:0] rd_q[$];
  logic [41:0] pin_q[$];
  int          err_count, cmp_count;
  psp_port_d_mux u_psp_port_d_mux (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .segment_lines, .pin_in, .pin_out, .pin_oe, .pin_pullup,
    .pin_input_en, .pin_seg, .ext_irq_zero_input, .timer1_capture_input);
  psp_pad_model u_psp_pad_model (.pin_out, .pin_oe, .src_level(src), .seg_level(segv), .pin_in, .segment_lines);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task report_and_stop;
    if (err_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [41:0] e, input logic [41:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // bounded wait for hready at a rising edge
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      err_count++;
      report_and_stop;
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= psp_pkg::PSP_HTRANS_NONSEQ;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // read data taken at the data phase edge
  always @(posedge hclk) begin
    if (rd_dp) chk("hrdata", {10'h0, rd_q.pop_front()}, {10'h0, hrdata});
    if (rd_dp) chk("hresp", 42'h0, {41'h0, hresp});
    rd_dp = hsel && hreadyout && htrans[1] && !hwrite;
  end
  always @(negedge hclk) begin
    if (pin_q.size() > 0) chk("pins", pin_q.pop_front(), {pin_oe, pin_out, pin_pullup, pin_input_en, pin_seg,
      ext_irq_zero_input, timer1_capture_input});
  end
  initial begin
    logic [31:0] c, dt, dr;
    logic [7:0]  s, sv, svr, cl, oe, ien, pad;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    src = 8'h00;
    segv = 8'h00;
    err_count = 0;
    cmp_count = 0;
    void'($urandom(32'hD4534A35));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(psp_pkg::PSP_OFS_CTRL, 32'h0);
    rd(psp_pkg::PSP_OFS_DIR, 32'h0);
    rd(8'h10, 32'h0);
    for (int i = 0; i < 40; i++) begin
      c = $urandom;
      dt = $urandom;
      dr = $urandom;
      s = $urandom;
      sv = $urandom;
      if (i < 16) c[6:0] = {i[2:0], c[3:2], i[3], 1'b1};
      bus(1'b1, psp_pkg::PSP_OFS_CTRL, c);
      bus(1'b1, psp_pkg::PSP_OFS_DATA, dt);
      bus(1'b1, psp_pkg::PSP_OFS_DIR, dr);
      bus(1'b1, psp_pkg::PSP_OFS_STATE, dt);
      src <= s;
      segv <= sv;
      repeat (4) @(posedge hclk);
      cl = {{2{c[0] && c[6:4] > 3'h1}}, {2{c[0] && c[6:4] > 3'h2}}, {2{c[0] && c[6:4] > 3'h3}}, {2{c[0] && c[6:4] > 3'h4}}};
      oe = dr[7:0] & ~cl;
      ien = ~cl;
      ien[1] = (c[0] | c[1]) ? (c[0] & c[1]) : 1'b1;
      pad = (oe & dt[7:0]) | (~oe & s);
      svr = {<<{sv}}; // segment line 15 lands on pin bit 7
      pin_q.push_back({oe, oe & dt[7:0], dt[7:0] & ~dr[7:0] & ~cl & {8{~c[2]}}, ien, cl & svr,
        pad[1] & ien[1], pad[0] & ien[0]});
      rd(psp_pkg::PSP_OFS_CTRL, c & 32'h77);
      rd(psp_pkg::PSP_OFS_DATA, dt & 32'hFF);
      rd(psp_pkg::PSP_OFS_STATE, {16'h0, cl, pad & ien});
    end
    repeat (2) @(posedge hclk);
    report_and_stop;
  end
endmodule
